//--- core/adcseq_pkg.sv
// Constants and carriers for the conversion sequencer.
// Assumes one peripheral clock at 50 MHz and a synchronous active-low reset.
package adcseq_pkg;

  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned RES_W           = 10;
  localparam logic [9:0]  RES_MAX         = 10'h3FF;
  localparam logic [4:0]  CONV_BASE_CYC   = 5'h0D;
  localparam logic [4:0]  SAMPLE_BASE_CYC = 5'h02;
  localparam int unsigned START_FIXED_CYC = 2;
  localparam logic [7:0]  PRESCALER_SELECT_RST       = 8'h00;
  localparam logic [3:0]  CHAN_RST        = 4'h0;
  localparam logic [2:0]  REF_RST         = 3'h0;
  localparam logic [2:0]  PRESCALER_SELECT_SEL_RST   = 3'h0;
  localparam logic [9:0]  RESULT_RST      = 10'h000;
  localparam logic [5:0]  CNT_RST         = 6'h00;

  typedef enum logic [1:0] {
    ADCSEQ_IDLE  = 2'b00,
    ADCSEQ_WAIT  = 2'b01,
    ADCSEQ_CONV  = 2'b10
  } adcseq_state_e;

  // Selection pair that is shadowed and locked
  typedef struct packed {
    logic [3:0] input_channel_select;
    logic [2:0] reference_select;
  } adcseq_sel_s;

  typedef struct packed {
    adcseq_state_e state;
    logic          start_conversion_bit;
    logic          result_ready_flag;
    logic          irq;
    logic [7:0]    prescaler_select_cnt;
    logic          adc_clk;
    logic [5:0]    cyc_cnt;
    adcseq_sel_s   active_sel;
    logic [9:0]    result;
    logic          ev_s1;
    logic          ev_s2;
    logic          ev_s3;
    logic          sample;
    logic          done;
  } adcseq_st_s;

endpackage

//--- core/adcseq_core.sv
// Conversion sequencer for a 10-bit successive-approximation converter.
// Assumes the analog core hands back a raw code and an over-range flag
// at the end of each conversion; event input is asynchronous.

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Writing start begins a conversion; bit reads one until single conversion ends.
// - Channel change mid-conversion takes effect only after the current one completes.
// - Result-ready sets at every finished conversion, interrupt enabled or not.
// - Interrupt requested only when flag, local enable and global enable are set.
// - With event start enabled each routed event arriving while idle triggers a conversion; one during a conversion starts none.
// - Event input is edge sensitive and sets the start bit.
// - Free-running: first start by software, later ones right after completion.
// - Free-running keeps start bit one; each conversion is 13+delay+length cycles.
// - Prescaler divides by select field, zeroed while converter is disabled.
// - Prescaler held reset when idle; start delay is half factor, counted from the start bit setting.
// - Conversion begins at next rising edge of the derived converter clock.
// - Base conversion 13 converter cycles; sample two cycles in; result at end.
// - Result-ready clears on result read or on writing one to it.
// - Sampling lasts 2 plus delay plus length converter cycles.
// - Selections shadowed; active follows shadow until the conversion begins, then frozen.
// - Active selection tracks again in the last cycle before result-ready.
// - Free-running auto-started conversion uses the shadow channel taken in the last cycle of the previous one.
// - Inputs over reference give code 0x3FF.
// - Debug halt stops the converter unless debug-run is set.
// - Selections take no effect while the converter is disabled.
// - Result is ten bits, right-adjusted.
// - Enabled interrupt stays up as long as its flag is set.
module adcseq_core
  import adcseq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Configuration
  input  wire logic        enable_i,
  input  wire logic        free_running_select_i,
  input  wire logic [2:0]  prescaler_select_i,
  input  wire logic [3:0]  sample_delay_field_i,
  input  wire logic [3:0]  sample_length_field_i,
  input  wire logic        start_event_input_enable_i,
  input  wire logic        debug_run_bit_i,
  input  wire logic        debug_halt_i,
  // Shadow selections from software
  input  wire adcseq_sel_s shadow_sel_i,
  // Commands and flags
  input  wire logic        start_write_i,
  input  wire logic        flag_clear_write_i,
  input  wire logic        result_read_i,
  input  wire logic        result_irq_enable_i,
  input  wire logic        global_irq_enable_i,
  // Event input, asynchronous
  input  wire logic        event_i,
  // Analog core
  input  wire logic [9:0]  core_code_i,
  input  wire logic        core_over_range_i,
  // Status and outputs
  output logic             start_conversion_bit_o,
  output logic             result_ready_flag_o,
  output logic             irq_o,
  output logic [9:0]       result_o,
  output adcseq_sel_s      active_sel_o,
  output logic             adc_clk_o,
  output logic             sample_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] prescaler_select_half(input logic [2:0] sel);
    prescaler_select_half = 8'((9'h002 << sel) >> 1);
  endfunction

  // Base plus both stretch fields; six bits hold the worst case of 43
  function automatic logic [5:0] cyc_sum(input logic [4:0] base, input logic [3:0] dly,
                                         input logic [3:0] len);
    cyc_sum = 6'(base) + 6'(dly) + 6'(len);
  endfunction

  adcseq_st_s r, nxt;
  logic       run;
  logic       ev_edge;
  logic       adc_rise;
  logic [5:0] conv_len;
  logic [5:0] samp_at;

  assign run      = enable_i && (debug_run_bit_i || !debug_halt_i);
  assign ev_edge  = r.ev_s2 && !r.ev_s3 && start_event_input_enable_i;
  assign conv_len = cyc_sum(CONV_BASE_CYC, sample_delay_field_i,
                            sample_length_field_i);
  assign samp_at  = cyc_sum(SAMPLE_BASE_CYC, sample_delay_field_i,
                            sample_length_field_i);

  always_comb begin
    nxt      = r;
    adc_rise = 1'b0;
    nxt.ev_s1 = event_i;
    nxt.ev_s2 = r.ev_s1;
    nxt.ev_s3 = r.ev_s2;
    nxt.sample = 1'b0;
    nxt.done   = 1'b0;
    // Prescaler: toggles the converter clock every half factor
    if (!enable_i || r.state == ADCSEQ_IDLE) begin
      nxt.prescaler_select_cnt = PRESCALER_SELECT_RST;
      nxt.adc_clk   = 1'b0;
    end else if (run) begin
      if (r.prescaler_select_cnt + 8'h01 >= prescaler_select_half(prescaler_select_i)) begin
        nxt.prescaler_select_cnt = PRESCALER_SELECT_RST;
        nxt.adc_clk   = !r.adc_clk;
        adc_rise      = !r.adc_clk;
      end else begin
        nxt.prescaler_select_cnt = r.prescaler_select_cnt + 8'h01;
      end
    end
    // Trigger from software or event
    if ((start_write_i || ev_edge) && enable_i) begin
      nxt.start_conversion_bit = 1'b1;
    end
    // Active selection follows shadow while not converting
    if (enable_i && r.state != ADCSEQ_CONV) begin
      nxt.active_sel = shadow_sel_i;
    end
    unique case (r.state)
      ADCSEQ_IDLE: begin
        if (nxt.start_conversion_bit && run) begin
          nxt.state = ADCSEQ_WAIT;
        end
      end
      ADCSEQ_WAIT: begin
        if (adc_rise) begin
          nxt.state   = ADCSEQ_CONV;
          nxt.cyc_cnt = CNT_RST;
        end
      end
      ADCSEQ_CONV: begin
        if (adc_rise) begin
          nxt.cyc_cnt = r.cyc_cnt + 6'h01;
          if (r.cyc_cnt + 6'h01 == samp_at) begin
            nxt.sample = 1'b1;
          end
          if (r.cyc_cnt + 6'h02 == conv_len) begin
            nxt.active_sel = shadow_sel_i;
          end
          if (r.cyc_cnt + 6'h01 == conv_len) begin
            nxt.done   = 1'b1;
            nxt.result = core_over_range_i ? RES_MAX : core_code_i;
            nxt.result_ready_flag = 1'b1;
            nxt.cyc_cnt = CNT_RST;
            if (free_running_select_i) begin
              nxt.state = ADCSEQ_CONV;
            end else begin
              nxt.state = ADCSEQ_IDLE;
              nxt.start_conversion_bit = 1'b0;
            end
          end
        end
      end
    endcase
    if (!enable_i) begin
      nxt.state = ADCSEQ_IDLE;
      nxt.start_conversion_bit = 1'b0;
    end
    // Set wins over clear
    if ((flag_clear_write_i || result_read_i) && !nxt.done) begin
      nxt.result_ready_flag = 1'b0;
    end
    nxt.irq = nxt.result_ready_flag && result_irq_enable_i
            && global_irq_enable_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '{
        state:                ADCSEQ_IDLE,
        start_conversion_bit: 1'b0,
        result_ready_flag:    1'b0,
        irq:                  1'b0,
        prescaler_select_cnt:            PRESCALER_SELECT_RST,
        adc_clk:              1'b0,
        cyc_cnt:              CNT_RST,
        active_sel:           '{CHAN_RST, REF_RST},
        result:               RESULT_RST,
        ev_s1:                1'b0,
        ev_s2:                1'b0,
        ev_s3:                1'b0,
        sample:               1'b0,
        done:                 1'b0
      };
    end else begin
      r <= nxt;
    end
  end

  assign start_conversion_bit_o = r.start_conversion_bit;
  assign result_ready_flag_o    = r.result_ready_flag;
  assign irq_o                  = r.irq;
  assign result_o               = r.result;
  assign active_sel_o           = r.active_sel;
  assign adc_clk_o              = r.adc_clk;
  assign sample_o               = r.sample;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_done;
    r.done;
  endsequence

  sequence s_adc_rise;
    adc_rise;
  endsequence

  sequence s_sample;
    sample_o;
  endsequence

  sequence s_sw_start;
    start_write_i && enable_i && r.state == ADCSEQ_IDLE;
  endsequence

  // Irq is built from the next flag, so it rises in the same edge as the flag
  AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_o == (result_ready_flag_o && $past(result_irq_enable_i && global_irq_enable_i)) ||
    $past(!rst_n_i))
    else $error("irq does not follow flag and enables");

  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_done |-> result_ready_flag_o)
    else $error("flag not set at completion");

  AST_SINGLE_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_done and !$past(free_running_select_i)) |-> !start_conversion_bit_o)
    else $error("start bit not cleared after single conversion");

  AST_FREE_RUNNING_SELECT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_done and $past(free_running_select_i) and $past(enable_i))
      |-> start_conversion_bit_o)
    else $error("start bit dropped in free-running");

  AST_PRESCALER_SELECT_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(enable_i) |-> r.prescaler_select_cnt == PRESCALER_SELECT_RST && !adc_clk_o)
    else $error("prescaler runs while disabled");

  AST_SEL_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($past(r.state) == ADCSEQ_CONV && r.state == ADCSEQ_CONV && !$past(adc_rise))
      |-> $stable(active_sel_o))
    else $error("selection changed during conversion");

  AST_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($past(result_read_i) && !r.done) |-> !result_ready_flag_o)
    else $error("flag not cleared by read");

  AST_OVER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_done and $past(core_over_range_i)) |-> result_o == RES_MAX)
    else $error("over-range result not maximum");

  AST_EVENT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ev_edge && enable_i) |=> start_conversion_bit_o)
    else $error("event did not set start bit");

  AST_WAIT_TO_CONV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((r.state == ADCSEQ_WAIT && enable_i) and s_adc_rise) |=> r.state == ADCSEQ_CONV)
    else $error("conversion did not begin on converter clock rise");

  AST_IDLE_PRESCALER_SELECT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    r.state == ADCSEQ_IDLE |=> r.prescaler_select_cnt == PRESCALER_SELECT_RST && !adc_clk_o)
    else $error("prescaler not held while idle");

  AST_HALT_FREEZE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enable_i && debug_halt_i && !debug_run_bit_i && r.state != ADCSEQ_IDLE)
      |=> $stable(r.prescaler_select_cnt) && $stable(adc_clk_o) && $stable(r.cyc_cnt))
    else $error("converter ran during debug halt");

  AST_SAMPLE_AT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_sample and $past(enable_i)) |-> r.cyc_cnt == $past(samp_at))
    else $error("sample not at end of sampling phase");

  AST_SAMPLE_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_sample |=> !sample_o)
    else $error("sample pulse longer than one cycle");

  AST_DONE_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_done and $past(enable_i)) |-> $past(r.cyc_cnt) + 6'h01 == $past(conv_len))
    else $error("conversion length wrong");

  AST_FREE_RUNNING_SELECT_NEXT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_done and $past(free_running_select_i) and $past(enable_i))
      |-> r.state == ADCSEQ_CONV && r.cyc_cnt == CNT_RST)
    else $error("free-running did not restart at once");

  AST_SEL_DISABLED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(enable_i) |-> $stable(active_sel_o))
    else $error("selection moved while disabled");

  AST_SEL_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($past(enable_i) && $past(r.state) != ADCSEQ_CONV)
      |-> active_sel_o == $past(shadow_sel_i))
    else $error("selection did not follow shadow");

  AST_IRQ_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !result_ready_flag_o |-> !irq_o)
    else $error("irq without flag");

  AST_IRQ_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (result_ready_flag_o && $past(result_irq_enable_i && global_irq_enable_i)) |-> irq_o)
    else $error("irq dropped while flag set");

  AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !r.done |-> $stable(result_o))
    else $error("result changed outside completion");

  // A held level must not retrigger
  AST_EVENT_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (start_event_input_enable_i && r.ev_s3 && r.state == ADCSEQ_IDLE
      && !start_conversion_bit_o && !start_write_i) |=> !start_conversion_bit_o)
    else $error("event level started a conversion");

  AST_BUSY_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    r.state != ADCSEQ_IDLE |-> start_conversion_bit_o)
    else $error("start bit low during conversion");

  AST_SW_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_sw_start |=> start_conversion_bit_o)
    else $error("software start not taken");

  AST_DISABLE_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(enable_i) |-> r.state == ADCSEQ_IDLE && !start_conversion_bit_o)
    else $error("converter active while disabled");

  AST_PRESCALER_SELECT_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(run) |-> r.prescaler_select_cnt < $past(prescaler_select_half(prescaler_select_i)))
    else $error("prescaler counter past its division");

  AST_FLAG_WR_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($past(flag_clear_write_i) && !r.done) |-> !result_ready_flag_o)
    else $error("flag not cleared by write");

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_done and $past(result_read_i)) |-> result_ready_flag_o)
    else $error("clear beat completion set");

endmodule

//--- testbench/adcseq_core_model.sv
// Analog converter core model for the sequencer bench.
// Assumes the sequencer pulses sample_i once per conversion and reads the code at completion.
module adcseq_core_model
  import adcseq_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // From sequencer
  input  wire adcseq_sel_s active_sel_i,
  input  wire logic        sample_i,
  // To sequencer
  output logic [9:0]       core_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Code carries the sampled channel so the bench can see which one was used
  always @(posedge clk_i) begin
    if (sample_i) begin
      core_code_o <= {active_sel_i.input_channel_select, 6'h2A};
    end
  end
endmodule

//--- testbench/adcseq_core_tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes a 50 MHz clock and the core model on the analog side.
module adcseq_core_tb import adcseq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_n_i = 0, enable_i = 0, free_running_select_i = 0;
  logic [2:0] prescaler_select_i = 3'h0;
  logic [3:0] sample_delay_field_i = 4'h0, sample_length_field_i = 4'h0;
  logic start_event_input_enable_i = 0, debug_run_bit_i = 0, debug_halt_i = 0;
  adcseq_sel_s shadow_sel_i = '0;
  logic start_write_i = 0, flag_clear_write_i = 0, result_read_i = 0;
  logic result_irq_enable_i = 0, global_irq_enable_i = 0, event_i = 0, core_over_range_i = 0;
  logic [9:0] core_code_i, result_o;
  logic start_conversion_bit_o, result_ready_flag_o, irq_o, adc_clk_o, sample_o;
  adcseq_sel_s active_sel_o;
  int err_total = 0, checks_done = 0, rises = 0, r0;
  always #10 clk_i = ~clk_i;
  always @(posedge adc_clk_o) rises++;
  adcseq_core i_adcseq_core (
    .clk_i                      (clk_i),
    .rst_n_i                    (rst_n_i),
    .enable_i                   (enable_i),
    .free_running_select_i      (free_running_select_i),
    .prescaler_select_i         (prescaler_select_i),
    .sample_delay_field_i       (sample_delay_field_i),
    .sample_length_field_i      (sample_length_field_i),
    .start_event_input_enable_i (start_event_input_enable_i),
    .debug_run_bit_i            (debug_run_bit_i),
    .debug_halt_i               (debug_halt_i),
    .shadow_sel_i               (shadow_sel_i),
    .start_write_i              (start_write_i),
    .flag_clear_write_i         (flag_clear_write_i),
    .result_read_i              (result_read_i),
    .result_irq_enable_i        (result_irq_enable_i),
    .global_irq_enable_i        (global_irq_enable_i),
    .event_i                    (event_i),
    .core_code_i                (core_code_i),
    .core_over_range_i          (core_over_range_i),
    .start_conversion_bit_o     (start_conversion_bit_o),
    .result_ready_flag_o        (result_ready_flag_o),
    .irq_o                      (irq_o),
    .result_o                   (result_o),
    .active_sel_o               (active_sel_o),
    .adc_clk_o                  (adc_clk_o),
    .sample_o                   (sample_o)
  );
  adcseq_core_model i_adcseq_core_model (.clk_i(clk_i), .active_sel_i(active_sel_o),
    .sample_i(sample_o), .core_code_o(core_code_i));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One-edge strobe: 0 start, 1 flag clear, 2 result read
  task strobe(input int k);
    @(posedge clk_i);
    case (k)
      0: start_write_i <= 1;
      1: flag_clear_write_i <= 1;
      default: result_read_i <= 1;
    endcase
    @(posedge clk_i);
    start_write_i <= 0;
    flag_clear_write_i <= 0;
    result_read_i <= 0;
    #1;
  endtask
  task end_of_test;
    $display("counts: checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wait_flag;
    int n;
    n = 0;
    while (result_ready_flag_o !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    if (n == 2000) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, n, 0);
      end_of_test;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1;
    cyc(1);
    chk({start_conversion_bit_o, result_ready_flag_o, irq_o, result_o}, 0);
    strobe(0);
    chk(start_conversion_bit_o, 0);
    $display("test reset done");
    // Setup order: channel and reference, then enable last
    // Divide by 64 gives a 781 kHz converter clock, inside the ten-bit range
    @(posedge clk_i) prescaler_select_i <= 3'h5;
    @(posedge clk_i) shadow_sel_i <= '{4'h1, 3'h2};
    @(posedge clk_i) enable_i <= 1;
    result_irq_enable_i <= 1;
    global_irq_enable_i <= 1;
    strobe(0);
    chk(start_conversion_bit_o, 1);
    cyc(100);
    @(posedge clk_i) shadow_sel_i <= '{4'h3, 3'h2};
    cyc(2);
    chk(active_sel_o, {4'h1, 3'h2});
    wait_flag;
    chk(start_conversion_bit_o, 0);
    chk(result_o, {4'h1, 6'h2A});
    chk(active_sel_o, {4'h3, 3'h2});
    cyc(1);
    chk(irq_o, 1);
    strobe(2);
    cyc(1);
    chk({result_ready_flag_o, irq_o}, 0);
    $display("test single done");
    @(posedge clk_i) global_irq_enable_i <= 0;
    core_over_range_i <= 1;
    strobe(0);
    wait_flag;
    chk(result_o, 10'h3FF);
    cyc(2);
    chk(irq_o, 0);
    strobe(1);
    chk(result_ready_flag_o, 0);
    core_over_range_i <= 0;
    $display("test polling done");
    @(posedge clk_i) start_event_input_enable_i <= 1;
    event_i <= 1;
    cyc(6);
    chk(start_conversion_bit_o, 1);
    wait_flag;
    chk(result_o, {4'h3, 6'h2A});
    strobe(2);
    cyc(80);
    chk(result_ready_flag_o, 0);
    event_i <= 0;
    start_event_input_enable_i <= 0;
    $display("test event done");
    @(posedge clk_i) free_running_select_i <= 1;
    sample_delay_field_i <= 4'h2;
    sample_length_field_i <= 4'h3;
    strobe(0);
    for (int i = 0; i < 3; i++) begin
      wait_flag;
      if (i > 0) chk(rises - r0, 13 + 2 + 3);
      r0 = rises;
      chk(result_o, {(i < 2) ? 4'h3 : 4'h5, 6'h2A});
      chk(start_conversion_bit_o, 1);
      strobe(2);
      if (i == 0) shadow_sel_i <= '{4'h5, 3'h2};
    end
    free_running_select_i <= 0;
    wait_flag;
    cyc(1);
    chk(start_conversion_bit_o, 0);
    strobe(2);
    $display("test free running done");
    @(posedge clk_i) debug_halt_i <= 1;
    strobe(0);
    cyc(100);
    chk(result_ready_flag_o, 0);
    debug_run_bit_i <= 1;
    wait_flag;
    chk(result_o, {4'h5, 6'h2A});
    @(posedge clk_i) enable_i <= 0;
    cyc(3);
    chk({adc_clk_o, start_conversion_bit_o}, 0);
    $display("test debug and disable done");
    end_of_test;
  end
endmodule
